/* File: hw/tfst_top.sv */
// fault disposition for terminate and stall models with a stall buffer
`timescale 1ns/1ps
`default_nettype none
module tfst_top #(
    parameter int DEPTH = tfst_pkg::STALL_DEPTH,
    parameter int TW    = tfst_pkg::TAG_W
) (
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    // ingress: result of translation for one transaction
    input  wire logic                        in_valid,
    output logic                             in_ready,
    input  wire logic [tfst_pkg::SID_W-1:0]  in_sid,
    input  wire logic                        in_ssid_valid,
    input  wire logic [tfst_pkg::SSID_W-1:0] in_ssid,
    input  wire logic [tfst_pkg::ADDR_W-1:0] in_addr,
    input  wire logic                        in_write,
    input  wire logic                        in_instr,
    input  wire logic                        in_priv,
    input  wire logic                        in_ns,
    input  wire logic                        in_fault,
    input  wire logic                        in_fault_s2,
    input  wire logic [2:0]                  in_fault_type,
    input  wire logic [tfst_pkg::SYND_W-1:0] in_synd,
    // configuration of the faulting stream
    input  wire logic                        abort_select,
    input  wire logic                        s1_record_enable,
    input  wire logic                        s1_stall_select,
    input  wire logic                        s1_stall_disable,
    input  wire logic                        s2_record_enable,
    input  wire logic                        s2_stall_select,
    input  wire logic                        translation_enable,
    input  wire logic                        termination_model_id,
    // response to client and forward toward memory
    output logic                             rsp_valid,
    output logic [1:0]                       rsp_code,
    output logic                             fwd_valid,
    // retry path back into the translator
    output logic                             retry_valid,
    input  wire logic                        retry_ready,
    output logic [$clog2(DEPTH)-1:0]         retry_index,
    // event queue
    input  wire logic                        evq_writable,
    output logic                             evt_valid,
    output logic                             evt_stall,
    output logic [TW-1:0]                    evt_tag,
    output logic [tfst_pkg::SID_W-1:0]       evt_sid,
    output logic [tfst_pkg::ADDR_W-1:0]      evt_addr,
    output logic [tfst_pkg::SYND_W-1:0]      evt_synd,
    output logic [3:0]                       evt_attr,
    output logic [2:0]                       evt_type,
    // software commands
    input  wire logic                        resume_command,
    input  wire logic                        resume_abort,
    input  wire logic [tfst_pkg::SID_W-1:0]  resume_sid,
    input  wire logic [TW-1:0]               resume_tag,
    input  wire logic                        stall_purge_command,
    input  wire logic [tfst_pkg::SID_W-1:0]  purge_sid,
    output logic                             stall_count_nz
);
    localparam int IW = $clog2(DEPTH);
    localparam int PW = tfst_pkg::ADDR_W - tfst_pkg::PAGE_LSB;

    ////////////////////////////////////////////////////////////////////////////////
    // stall buffer entries
    logic [DEPTH-1:0]         busy;
    logic [DEPTH-1:0]         recorded;
    logic [DEPTH-1:0]         pend_retry;
    logic [DEPTH-1:0]         pend_term;
    logic [DEPTH-1:0]         pend_abort;
    logic [DEPTH-1:0]         need_rec;
    logic [TW-1:0]            e_tag   [DEPTH];
    logic [IW-1:0]            e_owner [DEPTH];
    logic [tfst_pkg::SID_W-1:0]  e_sid  [DEPTH];
    logic [tfst_pkg::SSID_W-1:0] e_ssid [DEPTH];
    logic [DEPTH-1:0]         e_ssv;
    logic [PW-1:0]            e_page  [DEPTH];
    logic [DEPTH-1:0]         e_wr;
    logic [DEPTH-1:0]         e_in;
    logic [DEPTH-1:0]         e_pr;

    // tag is tied to the entry index, so an entry's tag stays reserved
    // until that entry leaves by accepted retry or terminate answer, or is cleared by disable
    logic [DEPTH-1:0] tag_used;
    logic             s1_term;
    logic             do_stall;
    logic             do_rec;
    logic             free_any;
    logic [IW-1:0]    free_idx;
    logic             dup_hit;
    logic [IW-1:0]    dup_idx;
    logic             take;
    logic [DEPTH-1:0] res_hit;
    logic [DEPTH-1:0] purge_hit;
    logic             rq_any;
    logic [IW-1:0]    rq_idx;
    logic             term_any;
    logic [IW-1:0]    term_idx;
    logic             term_go;

    assign s1_term  = !(s1_stall_select && !s1_stall_disable);
    assign do_stall = in_fault && (in_fault_s2 ? s2_stall_select : !s1_term);
    assign take     = in_valid && in_ready;
    // terminate answers yield to ingress so two responses never collide
    assign term_go  = term_any && !take;

    always_comb begin
        free_any = 1'b0;
        free_idx = '0;
        dup_hit  = 1'b0;
        dup_idx  = '0;
        for (int i = DEPTH-1; i >= 0; i--) begin
            if (!busy[i] && !tag_used[i]) begin
                free_any = 1'b1;
                free_idx = IW'(i);
            end
            // a duplicate must match an entry that owns a written record
            if (busy[i] && recorded[i] && e_sid[i] == in_sid && e_ssv[i] == in_ssid_valid
                && (!in_ssid_valid || e_ssid[i] == in_ssid)
                && e_page[i] == in_addr[tfst_pkg::ADDR_W-1:tfst_pkg::PAGE_LSB]
                && e_wr[i] == in_write && e_in[i] == in_instr
                && e_pr[i] == in_priv) begin
                dup_hit = 1'b1;
                dup_idx = IW'(i);
            end
        end
        do_rec = in_fault && (do_stall ? !dup_hit
                 : (in_fault_s2 ? s2_record_enable : s1_record_enable));
    end

    // a buffer slot must be free before any transaction is accepted
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            in_ready <= 1'b0;
        end else begin
            in_ready <= free_any && !take;
        end
    end

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            res_hit[i]   = resume_command && busy[i] && recorded[i]
                           && e_sid[i] == resume_sid && e_tag[i] == resume_tag;
            purge_hit[i] = stall_purge_command && busy[i] && !pend_retry[i]
                           && e_sid[i] == purge_sid;
        end
        rq_any   = 1'b0;
        rq_idx   = '0;
        term_any = 1'b0;
        term_idx = '0;
        for (int i = DEPTH-1; i >= 0; i--) begin
            if (busy[i] && (pend_retry[i] || (need_rec[i] && evq_writable))) begin
                rq_any = 1'b1;
                rq_idx = IW'(i);
            end
            if (busy[i] && pend_term[i]) begin
                term_any = 1'b1;
                term_idx = IW'(i);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // per-entry state
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_ent
            logic alloc;
            logic owner_ack;
            logic leave;
            assign alloc     = take && do_stall && free_idx == IW'(g);
            // acknowledgement of the owning record releases suppressed followers
            assign owner_ack = busy[g] && !recorded[g] && res_hit[e_owner[g]];
            assign leave     = (retry_valid && retry_ready && retry_index == IW'(g))
                               || (term_go && term_idx == IW'(g));
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    busy[g] <= 1'b0;
                    recorded[g] <= 1'b0;
                    pend_retry[g] <= 1'b0;
                    pend_term[g] <= 1'b0;
                    pend_abort[g] <= 1'b0;
                    need_rec[g] <= 1'b0;
                    tag_used[g] <= 1'b0;
                    e_owner[g] <= '0;
                end else if (!translation_enable) begin
                    busy[g] <= 1'b0;
                    tag_used[g] <= 1'b0;
                    pend_retry[g] <= 1'b0;
                    pend_term[g] <= 1'b0;
                    need_rec[g] <= 1'b0;
                    recorded[g] <= 1'b0;
                end else if (alloc) begin
                    busy[g] <= 1'b1;
                    tag_used[g] <= 1'b1;
                    // only a written record may own followers or be resumed
                    recorded[g] <= do_rec && evq_writable;
                    // queue not writable: hold and retry once it is
                    need_rec[g] <= do_rec && !evq_writable;
                    pend_retry[g] <= 1'b0;
                    pend_term[g] <= 1'b0;
                    e_owner[g] <= dup_hit ? dup_idx : IW'(g);
                end else begin
                    if (res_hit[g] || purge_hit[g] || owner_ack) begin
                        pend_retry[g] <= !(purge_hit[g] || (res_hit[g] && resume_abort));
                        pend_term[g] <= purge_hit[g] || (res_hit[g] && resume_abort);
                        pend_abort[g] <= resume_abort || purge_hit[g]
                                         || termination_model_id != tfst_pkg::TERM_BOTH;
                        recorded[g] <= 1'b0;
                    end
                    if (need_rec[g] && evq_writable) begin
                        pend_retry[g] <= 1'b1;
                        pend_term[g] <= 1'b0;
                        need_rec[g] <= 1'b0;
                        recorded[g] <= 1'b0;
                    end
                    if (leave) begin
                        busy[g] <= 1'b0;
                        pend_term[g] <= 1'b0;
                        pend_retry[g] <= 1'b0;
                        tag_used[g] <= 1'b0;
                    end
                end
            end
            always_ff @(posedge core_clk) begin
                if (alloc) begin
                    e_tag[g]  <= TW'(g);
                    e_sid[g]  <= in_sid;
                    e_ssid[g] <= in_ssid;
                    e_ssv[g]  <= in_ssid_valid;
                    e_page[g] <= in_addr[tfst_pkg::ADDR_W-1:tfst_pkg::PAGE_LSB];
                    e_wr[g]   <= in_write;
                    e_in[g]   <= in_instr;
                    e_pr[g]   <= in_priv;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // retry issue: stalled entry goes back to the translator as new
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            retry_valid <= 1'b0;
            retry_index <= '0;
        end else if (retry_valid && !retry_ready) begin
            retry_valid <= translation_enable;
        end else begin
            retry_valid <= rq_any && translation_enable && !(retry_valid && retry_index == rq_idx);
            retry_index <= rq_idx;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // client response and forward; stalled transactions are never forwarded and get a response only through a terminate answer
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_code  <= tfst_pkg::RSP_OKAY;
            fwd_valid <= 1'b0;
        end else begin
            rsp_valid <= (take && in_fault && !do_stall) || term_go;
            fwd_valid <= take && !in_fault;
            if (term_go) begin
                rsp_code <= pend_abort[term_idx] ? tfst_pkg::RSP_ABORT : tfst_pkg::RSP_RAZWI;
            end else if (in_fault_s2) begin
                rsp_code <= tfst_pkg::RSP_ABORT;
            end else if (abort_select || termination_model_id != tfst_pkg::TERM_BOTH) begin
                rsp_code <= tfst_pkg::RSP_ABORT;
            end else begin
                rsp_code <= tfst_pkg::RSP_RAZWI;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // event record: at most one per faulting transaction; stalled duplicates share the owner's record
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            evt_valid <= 1'b0;
            evt_stall <= 1'b0;
            evt_tag   <= '0;
            evt_sid   <= '0;
            evt_addr  <= '0;
            evt_synd  <= '0;
            evt_attr  <= '0;
            evt_type  <= tfst_pkg::FT_S1_TRANS;
        end else begin
            // a full queue loses the terminate record; nothing waits
            evt_valid <= take && do_rec && evq_writable;
            evt_stall <= do_stall;
            evt_tag   <= TW'(free_idx);
            evt_sid   <= in_sid;
            evt_addr  <= in_addr;
            evt_synd  <= in_synd;
            evt_attr  <= {in_write, in_instr, in_priv, in_ns};
            evt_type  <= in_fault_type;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stall_count_nz <= 1'b0;
        end else begin
            stall_count_nz <= |busy;
        end
    end
endmodule : tfst_top
`default_nettype wire

/* File: inc/tfst_pkg.sv */
// constants, types and behaviour notes of the translation fault stall/terminate block
package tfst_pkg;
    localparam int SID_W    = 16;
    localparam int SSID_W   = 20;
    localparam int ADDR_W   = 48;
    localparam int SYND_W   = 16;
    localparam int PAGE_LSB = 12;
    localparam int STALL_DEPTH = 4;
    localparam int TAG_W    = 2;
    // fault type encodings carried in the record
    localparam logic [2:0] FT_S1_TRANS = 3'h0;
    localparam logic [2:0] FT_S2_TRANS = 3'h1;
    localparam logic [2:0] FT_PERM     = 3'h2;
    localparam logic [2:0] FT_ADDR_SZ  = 3'h3;
    localparam logic [2:0] FT_ACCESS   = 3'h4;
    // client response encodings
    localparam logic [1:0] RSP_OKAY    = 2'h0;
    localparam logic [1:0] RSP_ABORT   = 2'h1;
    localparam logic [1:0] RSP_RAZWI   = 2'h2;
    // termination model id value that permits read-as-zero
    localparam logic TERM_BOTH = 1'h0;
    typedef enum logic [2:0] {
        TFST_IDLE  = 3'b001,
        TFST_EMIT  = 3'b010,
        TFST_RSP   = 3'b100
    } tfst_state_t;
endpackage : tfst_pkg

/* File: verif/tb.sv */
// self-checking bench for the fault stall/terminate block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic core_clk, rst, in_valid, in_ready, in_write, in_instr, in_priv, in_fault;
    logic in_fault_s2, abort_select, s1_record_enable, s1_stall_select, s1_stall_disable;
    logic s2_record_enable, s2_stall_select, translation_enable, evq_writable, rsp_valid;
    logic fwd_valid, retry_valid, retry_ready, evt_valid, evt_stall, stall_count_nz;
    logic resume_command, resume_abort, stall_purge_command;
    logic [1:0]  rsp_code, retry_index, evt_tag, resume_tag;
    logic [2:0]  in_fault_type, evt_type;
    logic [3:0]  evt_attr;
    logic [15:0] in_synd, evt_synd, evt_sid, resume_sid, purge_sid;
    logic [47:0] in_addr, evt_addr;
    logic [1:0]  tg [4];
    // s2 st dis abort r1 r2 writable code evt
    logic [9:0]  tt [6] = '{10'h06B, 10'h01C, 10'h1EB, 10'h21B, 10'h26A, 10'h062};
    int          fails, checks, cycles, n;
    tfst_top dut (.*, .in_sid(16'h0042), .in_ssid_valid(1'b0), .in_ssid(20'h0),
                  .in_ns(1'b1), .termination_model_id(1'b0));
    tfst_client cl (.*);
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            end_sim;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic end_sim;
        if (fails == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic run(input logic [47:0] a, input logic f, input logic s2, input logic [2:0] ft);
        cl.send(a, f, s2, ft);
        #1;
    endtask : run
    task automatic resume(input logic [1:0] t, input logic [15:0] sid);
        @(posedge core_clk);
        {resume_command, resume_tag, resume_sid} <= {1'b1, t, sid};
        @(posedge core_clk);
        resume_command <= 1'b0;
    endtask : resume
    task automatic wait_retry;
        for (n = 0; n < 20 && retry_valid !== 1'b1; n++) tick(1);
    endtask : wait_retry
    task automatic count(input int k);
        n = 0;
        repeat (k) begin
            tick(1);
            // a stalled entry leaves by retry or by a terminate answer
            n += (retry_ready === 1'b1) + (rsp_valid === 1'b1);
        end
    endtask : count
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, translation_enable, evq_writable, resume_tag, resume_sid, purge_sid} = 37'h1C_0000_0000;
        {abort_select, s1_record_enable, s1_stall_select, s1_stall_disable} = '0;
        {s2_record_enable, s2_stall_select, resume_command, resume_abort, stall_purge_command} = '0;
        {fails, checks, cycles} = '0;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        tick(2);
        run(48'h0000_0000_5000, 1'b0, 1'b0, 3'h0);
        chk("fwd_valid", fwd_valid, 1'b1);
        for (int i = 0; i < 6; i++) begin
            @(posedge core_clk);
            {s1_stall_select, s1_stall_disable, abort_select, s1_record_enable,
             s2_record_enable, evq_writable} <= tt[i][8:3];
            run(48'h0000_0001_0004, 1'b1, tt[i][9], {2'h0, tt[i][9]});
            chk("rsp_valid", rsp_valid, 1'b1);
            chk("rsp_code", rsp_code, tt[i][2:1]);
            chk("evt_valid", evt_valid, tt[i][0]);
        end
        @(posedge core_clk);
        {s1_stall_select, s1_stall_disable, evq_writable} <= 3'b101;
        for (int i = 0; i < 4; i++) begin
            run({32'h0000_0002, i[3:0], 12'h002}, 1'b1, 1'b0, i[2:0]);
            chk("evt_stall", evt_valid && evt_stall, 1'b1);
            chk("stall_answer", rsp_valid || fwd_valid, 1'b0);
            chk("evt_type", evt_type, i[2:0]);
            chk("evt_sid", evt_sid, 16'h0042);
            chk("evt_synd", evt_synd, {i[3:0], 12'h002});
            tg[i] = evt_tag;
        end
        tick(2);
        chk("in_ready_full", in_ready, 1'b0);
        resume(tg[0], 16'h0043);
        tick(5);
        chk("retry_wrong_sid", retry_valid, 1'b0);
        resume(tg[0], 16'h0042);
        wait_retry;
        chk("retry_valid", retry_valid, 1'b1);
        chk("retry_index", retry_index, tg[0]);
        tick(3);
        chk("in_ready_freed", in_ready, 1'b1);
        run(48'h0000_0002_0002, 1'b0, 1'b0, 3'h0);
        chk("retry_fwd", fwd_valid, 1'b1);
        // same page and attributes as a recorded stall
        run(48'h0000_0002_1002, 1'b1, 1'b0, 3'h1);
        chk("dup_suppressed", evt_valid, 1'b0);
        resume(tg[1], 16'h0042);
        count(40);
        chk("dup_retries", 48'(n), 48'h2);
        // write on a stalled page is unrelated
        run(48'h0000_0002_2003, 1'b1, 1'b0, 3'h4);
        chk("unrelated_rec", evt_valid && evt_stall, 1'b1);
        @(posedge core_clk);
        {stall_purge_command, purge_sid} <= {1'b1, 16'h0042};
        @(posedge core_clk);
        stall_purge_command <= 1'b0;
        count(60);
        chk("purge_ends", 48'(n), 48'h3);
        chk("purge_empty", stall_count_nz, 1'b0);
        @(posedge core_clk);
        evq_writable <= 1'b0;
        run(48'h0000_0002_5002, 1'b1, 1'b0, 3'h2);
        chk("unwritable_rec", evt_valid, 1'b0);
        @(posedge core_clk);
        evq_writable <= 1'b1;
        wait_retry;
        chk("writable_retry", retry_valid, 1'b1);
        tick(4);
        run(48'h0000_0002_6002, 1'b1, 1'b0, 3'h3);
        tg[0] = evt_tag;
        @(posedge core_clk);
        resume_abort <= 1'b1;
        resume(tg[0], 16'h0042);
        tick(1);
        chk("term_rsp", rsp_valid, 1'b1);
        chk("term_code", rsp_code, tfst_pkg::RSP_ABORT);
        run(48'h0000_0002_7002, 1'b1, 1'b0, 3'h3);
        tick(1);
        chk("stall_busy", stall_count_nz, 1'b1);
        @(posedge core_clk);
        translation_enable <= 1'b0;
        tick(3);
        chk("disable_frees", stall_count_nz, 1'b0);
        end_sim;
    end
endmodule : tb
`default_nettype wire

/* File: verif/tfst_client.sv */
// client model: presents transactions on ingress and accepts retries
`timescale 1ns/1ps
`default_nettype none
module tfst_client (
    input  wire logic   core_clk,
    input  wire logic   rst,
    input  wire logic   in_ready,
    input  wire logic   retry_valid,
    output logic        in_valid,
    output logic [47:0] in_addr,
    output logic        in_write,
    output logic        in_instr,
    output logic        in_priv,
    output logic [15:0] in_synd,
    output logic        in_fault,
    output logic        in_fault_s2,
    output logic [2:0]  in_fault_type,
    output logic        retry_ready
);
    initial begin
        in_valid = 1'b0;
        {in_addr, in_write, in_instr, in_priv, in_synd} = '0;
        {in_fault, in_fault_s2, in_fault_type} = '0;
    end
    // held until taken; attributes follow the address bits
    task automatic send(input logic [47:0] a, input logic f, input logic s2,
                        input logic [2:0] ft);
        @(posedge core_clk);
        in_valid <= 1'b1;
        {in_addr, in_synd, in_write, in_instr, in_priv} <= {a, a[15:0], a[0], a[1], a[2]};
        {in_fault, in_fault_s2, in_fault_type} <= {f, s2, ft};
        do @(posedge core_clk); while (in_ready !== 1'b1);
        in_valid <= 1'b0;
        // released lines must not keep the old value
        {in_addr, in_synd} <= ~{a, a[15:0]};
    endtask : send
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            retry_ready <= 1'b0;
        end else begin
            retry_ready <= retry_valid && !retry_ready;
        end
    end
endmodule : tfst_client
`default_nettype wire

/* File: verif/tfst_properties.sv */
// concurrent checks on the ports of the fault stall/terminate block
`timescale 1ns/1ps
`default_nettype none
module tfst_properties #(
    parameter int DEPTH = 4,
    parameter int TW    = 2
) (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        in_valid,
    input wire logic        in_ready,
    input wire logic [47:0] in_addr,
    input wire logic        in_write,
    input wire logic        in_fault,
    input wire logic        in_fault_s2,
    input wire logic [2:0]  in_fault_type,
    input wire logic        abort_select,
    input wire logic        s1_record_enable,
    input wire logic        s1_stall_select,
    input wire logic        s1_stall_disable,
    input wire logic        s2_record_enable,
    input wire logic        s2_stall_select,
    input wire logic        translation_enable,
    input wire logic        termination_model_id,
    input wire logic        rsp_valid,
    input wire logic [1:0]  rsp_code,
    input wire logic        fwd_valid,
    input wire logic        retry_valid,
    input wire logic        evq_writable,
    input wire logic        evt_valid,
    input wire logic        evt_stall,
    input wire logic [47:0] evt_addr,
    input wire logic [3:0]  evt_attr,
    input wire logic [2:0]  evt_type,
    input wire logic        stall_count_nz
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    logic take, stall, term, rec;
    assign take  = in_valid && in_ready && translation_enable;
    assign stall = in_fault_s2 ? s2_stall_select : s1_stall_select && !s1_stall_disable;
    assign term  = take && in_fault && !stall;
    assign rec   = in_fault_s2 ? s2_record_enable : s1_record_enable;
    ////////////////////////////////////////////////////////////////////////////////
    chk_clean_forward: assert property (
        take && !in_fault |=> fwd_valid && !rsp_valid && !evt_valid)
        else $error("clean transaction not forwarded alone");
    chk_s2_abort: assert property (
        term && in_fault_s2 |=> rsp_valid && rsp_code == tfst_pkg::RSP_ABORT)
        else $error("stage 2 terminate not aborted");
    chk_s1_code: assert property (
        term && !in_fault_s2 && (abort_select || termination_model_id == tfst_pkg::TERM_BOTH)
        |=> rsp_valid && rsp_code == ($past(abort_select) ? 2'h1 : 2'h2))
        else $error("stage 1 terminate code wrong");
    chk_term_record: assert property (
        term && rec && evq_writable ##1 evq_writable |-> evt_valid && !evt_stall)
        else $error("terminate record missing");
    chk_term_quiet: assert property (term && !rec |=> !evt_valid)
        else $error("terminate record without enable");
    chk_full_drop: assert property (
        term && !evq_writable ##1 !evq_writable |-> rsp_valid && !evt_valid)
        else $error("full queue held transaction or wrote record");
    chk_stall_hold: assert property (take && in_fault && stall |=> !rsp_valid && !fwd_valid)
        else $error("stalled transaction answered");
    chk_rec_fields: assert property (
        take && in_fault ##1 evt_valid |-> evt_addr == $past(in_addr)
        && evt_type == $past(in_fault_type) && evt_attr[3] == $past(in_write))
        else $error("record fields wrong");
    chk_stall_flag: assert property (
        take && in_fault && stall ##1 evt_valid |-> evt_stall ##1 stall_count_nz)
        else $error("stall record not flagged");
    chk_take_gap: assert property (in_valid && in_ready |=> !in_ready)
        else $error("ready after take");
    chk_retry_held: assert property (retry_valid |-> stall_count_nz)
        else $error("retry without stalled slot");
endmodule : tfst_properties
bind tfst_top tfst_properties #(.DEPTH(DEPTH), .TW(TW)) u_chk (.*);
`default_nettype wire
